// [rtl/scmc_cfg.svh]
/*
  constants for the system clock and mode control block: reset values,
  field codes and timing counts.
  assumes it is included by bare name from scmc_top, the only rtl module that includes it.
*/
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define SCMC_RST_DIV_SEL      3'h0
`define SCMC_RST_SRC_HIGH     1'h1
`define SCMC_RST_IDLE_ON_HALT 1'h1
`define SCMC_RST_FREQ_SEL     2'h0
`define SCMC_RST_IDLE_KEEP    1'h0

// --------------------------------------------------------------
// fast oscillator frequency codes
// --------------------------------------------------------------
`define SCMC_FREQ_8MHZ  2'h0
`define SCMC_FREQ_12MHZ 2'h1
`define SCMC_FREQ_16MHZ 2'h2

// --------------------------------------------------------------
// divider select codes (source high select low)
// --------------------------------------------------------------
`define SCMC_DIV_SLOW0 3'h0
`define SCMC_DIV_SLOW1 3'h1
`define SCMC_DIV_64    3'h2
`define SCMC_DIV_32    3'h3
`define SCMC_DIV_16    3'h4
`define SCMC_DIV_8     3'h5
`define SCMC_DIV_4     3'h6
`define SCMC_DIV_2     3'h7

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
// ready flag rises 15 to 16 ref_clk cycles after wake-up
`define SCMC_READY_CYCLES   16
`define SCMC_SLOW_READY_CYC 2

`endif

// [rtl/scmc_pkg.sv]
/*
  types for the system clock and mode control block.
  assumes scmc_cfg.svh is on the include path.
*/
package scmc_pkg;

  typedef enum logic [2:0] {
    SCMC_FAST,
    SCMC_SLOW,
    SCMC_SLEEP,
    SCMC_DEEP_IDLE,
    SCMC_LIGHT_IDLE
  } scmc_mode_t;

  typedef struct packed {
    logic [2:0] divider_select;
    logic       source_high_select;
    logic       idle_on_halt;
    logic [1:0] fast_freq_select;
    logic       idle_clock_keep;
  } scmc_ctrl_t;

  typedef struct packed {
    logic fast_osc_ready_flag;
    logic slow_osc_ready_flag;
    logic cpu_run;
    logic fast_osc_enable;
  } scmc_status_t;

endpackage

// [rtl/scmc_glitch_mux.sv]
/*
  glitch-free two-input clock-enable switch: the old source is released at
  a low phase before the new one is taken up, so no short phase escapes.
  assumes both sources arrive as single-cycle enables in the ref_clk domain.
*/
`timescale 1ns/1ps

module scmc_glitch_mux (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // sources
  input  wire logic sel_fast,
  input  wire logic fast_tick,
  input  wire logic slow_tick,
  // result
  output logic      sys_tick,
  output logic      fast_active
);

  logic fast_on_reg;
  logic fast_on_next;
  logic slow_on_reg;
  logic slow_on_next;

  // --------------------------------------------------------------
  // handover: one side off, then the other on, on a tick boundary
  // --------------------------------------------------------------
  always_comb begin
    fast_on_next = fast_on_reg;
    slow_on_next = slow_on_reg;
    if (sel_fast) begin
      if (slow_on_reg && slow_tick) begin
        slow_on_next = 1'b0;
      end else if (!slow_on_reg && !fast_on_reg) begin
        fast_on_next = 1'b1;
      end
    end else begin
      if (fast_on_reg && fast_tick) begin
        fast_on_next = 1'b0;
      end else if (!slow_on_reg && !fast_on_reg) begin
        slow_on_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fast_on_reg <= 1'b1;
      slow_on_reg <= 1'b0;
    end else begin
      fast_on_reg <= fast_on_next;
      slow_on_reg <= slow_on_next;
    end
  end

  assign sys_tick    = (fast_on_reg & fast_tick) | (slow_on_reg & slow_tick);
  assign fast_active = fast_on_reg;

endmodule

// [rtl/scmc_top.sv]
/*
  system clock and operating-mode control: fast and slow rc oscillator
  models as tick enables, system clock select and divide, mode machine.
  assumes the oscillators are modelled as enables derived from ref_clk, and that halt
  and wake arrive as synchronous one-cycle pulses from the cpu.
*/
// Contract
// - after reset the fast oscillator runs at its default 8 MHz setting.
// - a two-bit frequency field chooses 8, 12 or 16 MHz for the fast oscillator.
// - the slow clock comes from the slow rc oscillator at nominal 32 kHz.
// - the system clock is picked by source high select and the divider select field.
// - fast clock divided by 2 up to 64 are offered as system clock sources.
// - exactly one fast and one slow oscillator are always selected.
// - the system clock selection may be changed while the cpu runs.
// - on a switch to the slow clock the fast oscillator stops and its divided clocks vanish.
// - the oscillators also feed the watchdog and the time base.
// - fast and slow modes run the cpu from the fast-derived or slow clock.
// - in sleep and idle modes the cpu stops, slow clock runs, system clock only in light idle.
// - with source high select low, codes 000/001 pick slow, 010..111 pick fast /64../2.
// - halt with idle on halt low enters sleep.
// - halt with idle on halt high enters deep idle or, with idle clock keep, light idle.
// - the ready flag clears one cycle after sleep or deep idle is entered and rises 15 to 16 cycles after wake-up.
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_top #(
  parameter int FAST_DIV_8  = 5,
  parameter int FAST_DIV_12 = 3,
  parameter int FAST_DIV_16 = 2,
  parameter int SLOW_DIV    = 1250,
  parameter int READY_CYC   = `SCMC_READY_CYCLES
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // control bits
  input  wire scmc_pkg::scmc_ctrl_t  ctrl,
  // cpu events
  input  wire logic                  halt_pulse,
  input  wire logic                  wake_pulse,
  // clock enables out
  output logic                       sys_clk_en,
  output logic                       fast_clk_en,
  output logic                       slow_clk_en,
  output logic                       wdt_clk_en,
  output logic                       tbase_clk_en,
  // state
  output scmc_pkg::scmc_mode_t       mode,
  output scmc_pkg::scmc_status_t     status
);

  // refuse settings that the 12-bit and 8-bit counters cannot hold
  if (FAST_DIV_8 < 1 || FAST_DIV_12 < 1 || FAST_DIV_16 < 1 ||
      FAST_DIV_8 > 4096 || FAST_DIV_12 > 4096 || FAST_DIV_16 > 4096 ||
      SLOW_DIV < 2 || SLOW_DIV > 4096 || READY_CYC < 2 || READY_CYC > 255) begin : g_bad_param
    $error("scmc_top: bad parameter");
  end

  function automatic logic [5:0] div_mask(input logic [2:0] code);
    case (code)
      `SCMC_DIV_64: div_mask = 6'h3F;
      `SCMC_DIV_32: div_mask = 6'h1F;
      `SCMC_DIV_16: div_mask = 6'h0F;
      `SCMC_DIV_8:  div_mask = 6'h07;
      `SCMC_DIV_4:  div_mask = 6'h03;
      default:      div_mask = 6'h01;
    endcase
  endfunction

  scmc_pkg::scmc_mode_t mode_reg;
  scmc_pkg::scmc_mode_t mode_next;
  logic [11:0] fast_cnt_reg;
  logic [11:0] fast_cnt_next;
  logic [11:0] slow_cnt_reg;
  logic [11:0] slow_cnt_next;
  logic [5:0]  pre_reg;
  logic [5:0]  pre_next;
  logic [7:0]  rdy_cnt_reg;
  logic [7:0]  rdy_cnt_next;
  logic        hto_reg;
  logic        hto_next;
  logic [1:0]  lto_cnt_reg;
  logic [1:0]  lto_cnt_next;
  logic [11:0] fast_limit;
  logic        fast_run;
  logic        fast_tick;
  logic        slow_tick;
  logic        div_tick;
  logic        sel_slow;
  logic        sel_fast;
  logic        src_tick;
  logic        mux_tick;
  logic        mux_fast;
  logic        cpu_run;
  logic        sys_on;

  // --------------------------------------------------------------
  // oscillator models
  // --------------------------------------------------------------
  always_comb begin
    case (ctrl.fast_freq_select)
      `SCMC_FREQ_12MHZ: fast_limit = 12'(FAST_DIV_12 - 1);
      `SCMC_FREQ_16MHZ: fast_limit = 12'(FAST_DIV_16 - 1);
      default:          fast_limit = 12'(FAST_DIV_8 - 1);
    endcase
  end

  // fast oscillator runs in fast mode, in light idle with fast selected, and while the switch holds the fast side, also in sleep and deep idle
  assign sel_slow = !ctrl.source_high_select &&
                    (ctrl.divider_select == `SCMC_DIV_SLOW0 || ctrl.divider_select == `SCMC_DIV_SLOW1);
  assign sel_fast = !sel_slow;
  assign fast_run = (mode_reg == scmc_pkg::SCMC_FAST) ||
                    (mode_reg == scmc_pkg::SCMC_LIGHT_IDLE && sel_fast) || mux_fast;
  assign fast_tick = fast_run && (fast_cnt_reg >= fast_limit);
  assign slow_tick = (slow_cnt_reg == 12'(SLOW_DIV - 1));

  always_comb begin
    fast_cnt_next = fast_cnt_reg;
    if (!fast_run || fast_tick) begin
      fast_cnt_next = 12'h000;
    end else begin
      fast_cnt_next = fast_cnt_reg + 12'h001;
    end
    slow_cnt_next = slow_tick ? 12'h000 : slow_cnt_reg + 12'h001;
    pre_next = pre_reg;
    if (fast_tick) begin
      pre_next = pre_reg + 6'h01;
    end
  end

  // --------------------------------------------------------------
  // system clock source
  // --------------------------------------------------------------
  assign div_tick = fast_tick && ((pre_reg & div_mask(ctrl.divider_select)) == div_mask(ctrl.divider_select));
  assign src_tick = ctrl.source_high_select ? fast_tick : div_tick;

  scmc_glitch_mux u_mux (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .sel_fast    (sel_fast),
    .fast_tick   (src_tick),
    .slow_tick   (slow_tick),
    .sys_tick    (mux_tick),
    .fast_active (mux_fast)
  );

  // --------------------------------------------------------------
  // operating modes
  // --------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      scmc_pkg::SCMC_FAST,
      scmc_pkg::SCMC_SLOW: begin
        if (halt_pulse) begin
          if (!ctrl.idle_on_halt) begin
            mode_next = scmc_pkg::SCMC_SLEEP;
          end else if (ctrl.idle_clock_keep) begin
            mode_next = scmc_pkg::SCMC_LIGHT_IDLE;
          end else begin
            mode_next = scmc_pkg::SCMC_DEEP_IDLE;
          end
        end else begin
          mode_next = sel_slow ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_FAST;
        end
      end
      default: begin
        if (wake_pulse) begin
          mode_next = sel_slow ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_FAST;
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // ready flags
  // --------------------------------------------------------------
  always_comb begin
    rdy_cnt_next = rdy_cnt_reg;
    hto_next     = hto_reg;
    if (mode_reg == scmc_pkg::SCMC_SLEEP || mode_reg == scmc_pkg::SCMC_DEEP_IDLE) begin
      rdy_cnt_next = 8'h00;
      hto_next     = 1'b0;
    end else if (!hto_reg) begin
      if (rdy_cnt_reg == 8'(READY_CYC - 1)) begin
        hto_next = 1'b1;
      end else begin
        rdy_cnt_next = rdy_cnt_reg + 8'h01;
      end
    end
    lto_cnt_next = lto_cnt_reg;
    if (slow_tick && lto_cnt_reg != 2'(`SCMC_SLOW_READY_CYC)) begin
      lto_cnt_next = lto_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_reg     <= scmc_pkg::SCMC_FAST;
      fast_cnt_reg <= 12'h000;
      slow_cnt_reg <= 12'h000;
      pre_reg      <= 6'h00;
      rdy_cnt_reg  <= 8'h00;
      hto_reg      <= 1'b0;
      lto_cnt_reg  <= 2'h0;
    end else begin
      mode_reg     <= mode_next;
      fast_cnt_reg <= fast_cnt_next;
      slow_cnt_reg <= slow_cnt_next;
      pre_reg      <= pre_next;
      rdy_cnt_reg  <= rdy_cnt_next;
      hto_reg      <= hto_next;
      lto_cnt_reg  <= lto_cnt_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign cpu_run = (mode_reg == scmc_pkg::SCMC_FAST) || (mode_reg == scmc_pkg::SCMC_SLOW);
  assign sys_on  = cpu_run || (mode_reg == scmc_pkg::SCMC_LIGHT_IDLE);

  assign sys_clk_en   = sys_on & mux_tick;
  assign fast_clk_en  = fast_tick;
  assign slow_clk_en  = slow_tick;
  assign wdt_clk_en   = slow_tick;
  assign tbase_clk_en = ctrl.source_high_select ? (sys_on & mux_tick) : slow_tick;
  assign mode         = mode_reg;
  assign status       = '{fast_osc_ready_flag: hto_reg,
                          slow_osc_ready_flag: (lto_cnt_reg == 2'(`SCMC_SLOW_READY_CYC)),
                          cpu_run:             cpu_run,
                          fast_osc_enable:     fast_run};

endmodule

// [verification/scmc_top_monitor.sv]
/*
  checker for scmc_top: mode entry and wake, cpu clock gating, slow tick rate, ready flag timing.
  assumes it is bound to scmc_top and sees only its ports.
*/
`timescale 1ns/1ps

module scmc_top_monitor #(
  parameter int SLOW_DIV = 1250
) (
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  input wire scmc_pkg::scmc_ctrl_t   ctrl,
  input wire logic                   halt_pulse,
  input wire logic                   wake_pulse,
  input wire logic                   sys_clk_en,
  input wire logic                   fast_clk_en,
  input wire logic                   slow_clk_en,
  input wire logic                   wdt_clk_en,
  input wire logic                   tbase_clk_en,
  input wire scmc_pkg::scmc_mode_t   mode,
  input wire scmc_pkg::scmc_status_t status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic run, stopped, off_any, seen_reg, seen_next;
  int   gap_reg, gap_next;
  assign run     = (mode == scmc_pkg::SCMC_FAST) || (mode == scmc_pkg::SCMC_SLOW);
  assign stopped = (mode == scmc_pkg::SCMC_SLEEP) || (mode == scmc_pkg::SCMC_DEEP_IDLE);
  assign off_any = !run;
  // cycles since the last slow tick
  always_comb begin
    gap_next  = slow_clk_en ? 0 : gap_reg + 1;
    seen_next = seen_reg | slow_clk_en;
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      gap_reg  <= 0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= gap_next;
      seen_reg <= seen_next;
    end
  end
  sequence s_left_stop;
    $past(stopped) && run;
  endsequence
  sequence s_flag_low8;
    (!status.fast_osc_ready_flag) [*8];
  endsequence
  // sixteen cycles in a row outside sleep and deep idle
  sequence s_kept_up;
    (!stopped) [*8] ##1 (!stopped) [*8];
  endsequence
  a_halt_sleep: assert property (run && halt_pulse && !ctrl.idle_on_halt |=> mode == scmc_pkg::SCMC_SLEEP)
    else $error("halt did not enter sleep");
  a_halt_idle: assert property (run && halt_pulse && ctrl.idle_on_halt |=>
    mode == ($past(ctrl.idle_clock_keep) ? scmc_pkg::SCMC_LIGHT_IDLE : scmc_pkg::SCMC_DEEP_IDLE))
    else $error("halt chose wrong idle");
  a_wake_to_fast: assert property (off_any && wake_pulse && ctrl.source_high_select |=>
    mode == scmc_pkg::SCMC_FAST) else $error("wake did not resume fast");
  a_follow_slow: assert property (run && !halt_pulse && !ctrl.source_high_select &&
    ctrl.divider_select < 3'h2 |=> mode == scmc_pkg::SCMC_SLOW) else $error("slow select not followed");
  a_halt_ignored: assert property (off_any && halt_pulse && !wake_pulse |=> $stable(mode))
    else $error("halt acted in stop mode");
  a_cpu_off: assert property (stopped |-> !sys_clk_en && !status.cpu_run)
    else $error("cpu clock in stop mode");
  a_wdt_slow: assert property (wdt_clk_en == slow_clk_en)
    else $error("watchdog clock differs from slow clock");
  a_slow_rate: assert property (slow_clk_en && seen_reg |-> gap_reg == SLOW_DIV - 1)
    else $error("slow tick spacing wrong");
  a_ready_low: assert property (stopped && $past(stopped) |-> !status.fast_osc_ready_flag)
    else $error("ready flag high in stop");
  a_ready_early: assert property (s_left_stop |-> s_flag_low8)
    else $error("ready flag rose too early");
  a_ready_delay: assert property (s_left_stop ##0 s_kept_up |=> status.fast_osc_ready_flag)
    else $error("ready flag timing wrong");
endmodule

bind scmc_top scmc_top_monitor #(.SLOW_DIV(SLOW_DIV)) i_scmc_top_monitor (.ref_clk(ref_clk), .resetn(resetn),
  .ctrl(ctrl), .halt_pulse(halt_pulse), .wake_pulse(wake_pulse), .sys_clk_en(sys_clk_en), .fast_clk_en(fast_clk_en),
  .slow_clk_en(slow_clk_en), .wdt_clk_en(wdt_clk_en), .tbase_clk_en(tbase_clk_en), .mode(mode), .status(status));

// [verification/scmc_top_tb.sv]
/*
  self-checking bench for scmc_top with a cycle model of the mode machine and ready flag.
  assumes the shortened slow divider and the fast tick counts set below.
*/
`timescale 1ns/1ps

module scmc_top_tb;
  localparam int SDIV = 4;
  logic                   ref_clk, resetn, halt_pulse, wake_pulse;
  logic                   sys_clk_en, fast_clk_en, slow_clk_en, wdt_clk_en, tbase_clk_en;
  scmc_pkg::scmc_ctrl_t   ctrl;
  scmc_pkg::scmc_mode_t   mode, exp_mode, prev_exp;
  scmc_pkg::scmc_status_t status;
  int                     failures, checks_done, cyc, rdy_cnt, n, i, dummy;
  int                     fper[4] = '{5, 3, 2, 5};

  scmc_top #(.FAST_DIV_8(5), .FAST_DIV_12(3), .FAST_DIV_16(2), .SLOW_DIV(SDIV)) i_scmc_top (
    .ref_clk(ref_clk), .resetn(resetn), .ctrl(ctrl), .halt_pulse(halt_pulse), .wake_pulse(wake_pulse),
    .sys_clk_en(sys_clk_en), .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en), .wdt_clk_en(wdt_clk_en),
    .tbase_clk_en(tbase_clk_en), .mode(mode), .status(status));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic check_mode(input scmc_pkg::scmc_mode_t got, input scmc_pkg::scmc_mode_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t mode %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic check_gap(input int got, input int exp, input string msg);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("FAIL %0t %s got %0d want %0d", $time, msg, got, exp);
    end
  endtask
  // cycles between two ticks of the system or the fast enable
  task automatic tick_gap(input bit use_sys, output int g);
    int k;
    @(negedge ref_clk);
    for (k = 0; k < 4000 && (use_sys ? sys_clk_en : fast_clk_en) !== 1'b1; k++) @(negedge ref_clk);
    g = 0;
    do begin
      @(negedge ref_clk);
      g++;
    end while ((use_sys ? sys_clk_en : fast_clk_en) !== 1'b1 && g < 4000);
  endtask
  task automatic pulse(input bit wake);
    @(posedge ref_clk);
    if (wake) wake_pulse <= 1'b1;
    else halt_pulse <= 1'b1;
    @(posedge ref_clk);
    wake_pulse <= 1'b0;
    halt_pulse <= 1'b0;
  endtask
  function automatic scmc_pkg::scmc_mode_t sel_mode(input scmc_pkg::scmc_ctrl_t c);
    return (c.source_high_select || c.divider_select >= 3'h2) ? scmc_pkg::SCMC_FAST : scmc_pkg::SCMC_SLOW;
  endfunction

  // --------------------------------------------------------------
  // reference model and per-cycle comparison
  // --------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 60000) begin
      failures++;
      test_done();
    end else begin
      prev_exp = exp_mode;
      if (!resetn) begin
        exp_mode = scmc_pkg::SCMC_FAST;
        rdy_cnt = 0;
      end else if (exp_mode inside {scmc_pkg::SCMC_FAST, scmc_pkg::SCMC_SLOW}) begin
        rdy_cnt++;
        if (!halt_pulse) exp_mode = sel_mode(ctrl);
        else if (!ctrl.idle_on_halt) exp_mode = scmc_pkg::SCMC_SLEEP;
        else exp_mode = ctrl.idle_clock_keep ? scmc_pkg::SCMC_LIGHT_IDLE : scmc_pkg::SCMC_DEEP_IDLE;
      end else if (wake_pulse) begin
        rdy_cnt = (exp_mode == scmc_pkg::SCMC_LIGHT_IDLE) ? rdy_cnt + 1 : 0;
        exp_mode = sel_mode(ctrl);
      end else if (exp_mode == scmc_pkg::SCMC_LIGHT_IDLE) rdy_cnt++;
    end
  end
  always @(negedge ref_clk) begin
    if (resetn) begin
      check_mode(mode, exp_mode);
      check_bit(status.cpu_run, exp_mode inside {scmc_pkg::SCMC_FAST, scmc_pkg::SCMC_SLOW}, "cpu run");
      if (!ctrl.source_high_select) check_bit(tbase_clk_en, slow_clk_en, "time base tick");
      if (exp_mode inside {scmc_pkg::SCMC_SLEEP, scmc_pkg::SCMC_DEEP_IDLE}) begin
        if (prev_exp == exp_mode) check_bit(status.fast_osc_ready_flag, 1'b0, "ready flag in stop");
        check_bit(sys_clk_en, 1'b0, "system tick in stop");
      end else if (rdy_cnt <= 13) check_bit(status.fast_osc_ready_flag, 1'b0, "ready flag early");
      else if (rdy_cnt >= 17) check_bit(status.fast_osc_ready_flag, 1'b1, "ready flag late");
      check_bit(wdt_clk_en, slow_clk_en, "watchdog tick");
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    halt_pulse = 1'b0;
    wake_pulse = 1'b0;
    ctrl = '{divider_select: 3'h0, source_high_select: 1'b1, idle_on_halt: 1'b1, fast_freq_select: 2'h0,
             idle_clock_keep: 1'b0};
    dummy = $urandom(38);
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (30) @(posedge ref_clk);
    @(negedge ref_clk);
    check_bit(status.slow_osc_ready_flag, 1'b1, "slow ready flag");
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      ctrl.fast_freq_select <= i[1:0];
      repeat (20) @(posedge ref_clk);
      tick_gap(1'b0, n);
      check_gap(n, fper[i], "fast period");
      tick_gap(1'b1, n);
      check_gap(n, fper[i], "undivided system period");
    end
    @(posedge ref_clk);
    ctrl.fast_freq_select <= 2'h0;
    ctrl.source_high_select <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      @(posedge ref_clk);
      ctrl.divider_select <= i[2:0];
      repeat (700) @(posedge ref_clk);
      tick_gap(1'b1, n);
      check_gap(n, (i >= 2) ? 5 << (8 - i) : SDIV, "divided system period");
    end
    for (i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      ctrl <= scmc_pkg::scmc_ctrl_t'(8'($urandom));
      pulse(1'b1);
      pulse(1'b0);
      repeat ($urandom_range(2, 8)) @(posedge ref_clk);
      pulse(1'b0);
      repeat ($urandom_range(1, 6)) @(posedge ref_clk);
      pulse(1'b1);
      repeat ($urandom_range(20, 40)) @(posedge ref_clk);
    end
    test_done();
  end
endmodule
